// ### verification/chs_battery_model.sv
// battery sense network: turns battery voltage and charge current into comparator levels
// assumes levels in percent of overcharge target voltage and of bulk current
`timescale 1ns/1ps
module chs_battery_model #(
    parameter int LOW_PCT = 60,
    parameter int FLOAT_PCT = 90,
    parameter int TAPER_PCT = 10
) (
    input wire logic [7:0] i_volt_pct,
    input wire logic [7:0] i_cur_pct,
    output logic o_battery_low_sense,
    output logic o_volt_above_95pct,
    output logic o_volt_below_90pct,
    output logic o_current_taper_sense
);
    // float voltage sits below the overcharge target, so its 90% point is scaled
    always_comb begin
        o_battery_low_sense = int'(i_volt_pct) < LOW_PCT;
        o_volt_above_95pct = int'(i_volt_pct) > 95;
        o_volt_below_90pct = int'(i_volt_pct) * 100 < 90 * FLOAT_PCT;
        o_current_taper_sense = int'(i_cur_pct) < TAPER_PCT;
    end
endmodule

// ### verification/tb.sv
// bench for the charge sequencer: walks every state arc except the bulk and overcharge exits to trickle through the battery model
// assumes outputs follow an input change on the third rising edge
`timescale 1ns/1ps
module tb;
    import chs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic uvlo = 1'b0;
    logic [7:0] volt = 8'h1E;
    logic [7:0] cur = 8'h64;
    logic low, v95, v90, taper, b0, b1, flt, amp, trk;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    initial begin
        forever #5 clk = ~clk;
    end
    chs_battery_model model_u (.i_volt_pct(volt), .i_cur_pct(cur), .o_battery_low_sense(low),
        .o_volt_above_95pct(v95), .o_volt_below_90pct(v90), .o_current_taper_sense(taper));
    chs_sequencer dut_u (.i_sys_clk(clk), .i_rst(rst), .i_uvlo(uvlo), .i_battery_low_sense(low),
        .i_volt_above_95pct(v95), .i_volt_below_90pct(v90), .i_current_taper_sense(taper),
        .o_state_code_bit0(b0), .o_state_code_bit1(b1), .o_float_indicator(flt),
        .o_voltage_error_amp_en(amp), .o_trickle_bias_en(trk));
    // ****************************************
    // compare and drive tasks
    // ****************************************
    task automatic final_report();
        $display("mismatches %0d, comparisons %0d", bad_count, samples_checked);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // float and amp enable follow from the state code alone
    task automatic chk(input logic [1:0] code);
        logic [4:0] got;
        logic [4:0] exp;
        got = {b1, b0, flt, amp, trk};
        exp = {code, code == CHS_CODE_FLOAT, code != CHS_CODE_TRICKLE, code == CHS_CODE_TRICKLE};
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t outputs %b expected %b", $time, got, exp);
        end
    endtask
    // old state must hold for two edges, new state appears on the third
    task automatic step(input logic [7:0] v, input logic [7:0] c, input logic u,
        input logic [1:0] old_c, input logic [1:0] new_c);
        @(negedge clk);
        volt = v;
        cur = c;
        uvlo = u;
        repeat (2) @(posedge clk);
        #1 chk(old_c);
        @(posedge clk);
        #1 chk(new_c);
    endtask
    task automatic t_walk();
        step(8'h46, 8'h64, 1'b0, CHS_CODE_TRICKLE, CHS_CODE_BULK);
        step(8'h61, 8'h64, 1'b0, CHS_CODE_BULK, CHS_CODE_OVERCHARGE);
        step(8'h61, 8'h05, 1'b0, CHS_CODE_OVERCHARGE, CHS_CODE_FLOAT);
        step(8'h51, 8'h05, 1'b0, CHS_CODE_FLOAT, CHS_CODE_FLOAT);
        step(8'h50, 8'h05, 1'b0, CHS_CODE_FLOAT, CHS_CODE_BULK);
        step(8'h50, 8'h05, 1'b0, CHS_CODE_BULK, CHS_CODE_BULK);
    endtask
    task automatic t_low();
        step(8'h61, 8'h05, 1'b0, CHS_CODE_BULK, CHS_CODE_OVERCHARGE);
        step(8'h1E, 8'h05, 1'b0, CHS_CODE_FLOAT, CHS_CODE_TRICKLE);
        step(8'h61, 8'h05, 1'b0, CHS_CODE_TRICKLE, CHS_CODE_BULK);
        @(posedge clk);
        #1 chk(CHS_CODE_OVERCHARGE);
        @(posedge clk);
        #1 chk(CHS_CODE_FLOAT);
    endtask
    task automatic t_lockout();
        step(8'h61, 8'h05, 1'b1, CHS_CODE_FLOAT, CHS_CODE_TRICKLE);
        step(8'h46, 8'h64, 1'b0, CHS_CODE_TRICKLE, CHS_CODE_BULK);
    endtask
    task automatic t_mid_reset();
        @(negedge clk);
        rst = 1'b1;
        #1 chk(CHS_CODE_TRICKLE);
        @(negedge clk);
        rst = 1'b0;
        @(posedge clk);
        #1 chk(CHS_CODE_TRICKLE);
        repeat (4) @(posedge clk);
        #1 chk(CHS_CODE_BULK);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            final_report();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        #1 chk(CHS_CODE_TRICKLE);
        @(negedge clk);
        rst = 1'b0;
        t_walk();
        t_low();
        t_lockout();
        t_mid_reset();
        final_report();
    end
endmodule

// ### verilog/chs_pkg.sv
// package for the charge state sequencer: state enum, output codes, sync depth
// assumes a single 100 MHz sampling clock and an active-high async reset
package chs_pkg;

    typedef enum {
        CHS_TRICKLE,
        CHS_BULK,
        CHS_OVERCHARGE,
        CHS_FLOAT
    } chs_state_t;

    // state code bits {bit1, bit0} per state
    localparam logic [1:0] CHS_CODE_TRICKLE = 2'h0;
    localparam logic [1:0] CHS_CODE_BULK = 2'h1;
    localparam logic [1:0] CHS_CODE_OVERCHARGE = 2'h2;
    localparam logic [1:0] CHS_CODE_FLOAT = 2'h3;

    // reset values of the outputs (trickle state)
    localparam logic [1:0] CHS_RST_CODE = 2'h0;
    localparam logic CHS_RST_FLOAT = 1'h0;

    // synchroniser depth for comparator inputs
    localparam int CHS_SYNC_STAGES = 2;

endpackage

// ### verilog/chs_sequencer.sv
// four-state charge sequencer: trickle, bulk, overcharge, float
// assumes comparator decisions arrive as asynchronous levels, high = condition true
// Contract
// - in trickle both code bits and the float indicator are 0.
// - in bulk code bit1 and float indicator are 0 and code bit0 is 1.
// - in overcharge code bit0 and float indicator are 0 and code bit1 is 1.
// - in float both code bits and the float indicator are 1.
// - a low battery sense forces the float indicator low.
// - trickle goes to bulk once the battery-low sense drops low (battery above its reference) and lockout is clear.
// - in trickle the voltage amp is high impedance and trickle bias is steered in.
// - in bulk the voltage amp is enabled to command full charge current.
// - bulk goes to overcharge when battery voltage exceeds 95% of target.
// - overcharge goes to float when current tapers below threshold.
// - float returns to bulk when battery voltage drops below 90% of float voltage.
// - the float indicator is high exactly in the float state.
// - a detected low battery places the charger in trickle.
`timescale 1ns/1ps
module chs_sequencer
    import chs_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_uvlo,
    input wire logic i_battery_low_sense,
    input wire logic i_volt_above_95pct,
    input wire logic i_volt_below_90pct,
    input wire logic i_current_taper_sense,
    output logic o_state_code_bit0,
    output logic o_state_code_bit1,
    output logic o_float_indicator,
    output logic o_voltage_error_amp_en,
    output logic o_trickle_bias_en
);

    // ****************************************
    // input synchronisation
    // ****************************************
    logic [3:0] raw_in;
    logic [3:0] syn_in;
    logic lockout_raw;
    logic bat_low;
    logic above_95;
    logic below_90;
    logic taper;

    assign raw_in = {i_current_taper_sense, i_volt_below_90pct, i_volt_above_95pct, i_battery_low_sense};
    assign lockout_raw = i_uvlo;

    chs_sync #(
        .WIDTH(4)
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_async(raw_in),
        .o_sync(syn_in)
    );

    assign bat_low = syn_in[0];
    assign above_95 = syn_in[1];
    assign below_90 = syn_in[2];
    assign taper = syn_in[3];

    // ****************************************
    // state register
    // ****************************************
    typedef struct packed {
        chs_state_t state;
        logic [1:0] code;
        logic flt;
        logic vea_en;
        logic trk_en;
        logic [1:0] lock;
    } chs_st_t;

    chs_st_t s_q;
    chs_st_t s_d;

    function automatic logic [1:0] chs_code(input chs_state_t st);
        case (st)
            CHS_BULK: chs_code = CHS_CODE_BULK;
            CHS_OVERCHARGE: chs_code = CHS_CODE_OVERCHARGE;
            CHS_FLOAT: chs_code = CHS_CODE_FLOAT;
            default: chs_code = CHS_CODE_TRICKLE;
        endcase
    endfunction

    always_comb begin
        chs_state_t nxt;
        nxt = s_q.state;
        s_d = s_q;
        // lockout two-flop sync
        // resets to asserted so the comparator sync has flushed before any arc is taken
        s_d.lock = {s_q.lock[0], lockout_raw};
        case (s_q.state)
            CHS_TRICKLE: begin
                if (!bat_low) begin
                    nxt = CHS_BULK;
                end
            end
            CHS_BULK: begin
                if (above_95) begin
                    nxt = CHS_OVERCHARGE;
                end
            end
            CHS_OVERCHARGE: begin
                if (taper) begin
                    nxt = CHS_FLOAT;
                end
            end
            CHS_FLOAT: begin
                if (below_90) begin
                    nxt = CHS_BULK;
                end
            end
            default: nxt = CHS_TRICKLE;
        endcase
        // low battery wins; lockout holds trickle
        if (bat_low || s_q.lock[1]) begin
            nxt = CHS_TRICKLE;
        end
        s_d.state = nxt;
        s_d.code = chs_code(nxt);
        s_d.flt = (nxt == CHS_FLOAT);
        s_d.vea_en = (nxt != CHS_TRICKLE);
        s_d.trk_en = (nxt == CHS_TRICKLE);
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q.state <= CHS_TRICKLE;
            s_q.code <= CHS_RST_CODE;
            s_q.flt <= CHS_RST_FLOAT;
            s_q.vea_en <= 1'h0;
            s_q.trk_en <= 1'h1;
            s_q.lock <= 2'h3;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_state_code_bit0 = s_q.code[0];
    assign o_state_code_bit1 = s_q.code[1];
    assign o_float_indicator = s_q.flt;
    assign o_voltage_error_amp_en = s_q.vea_en;
    assign o_trickle_bias_en = s_q.trk_en;

    // ****************************************
    // checks
    // ****************************************
    sequence seq_in_overcharge;
        s_q.state == CHS_OVERCHARGE;
    endsequence

    sequence seq_taper_seen;
        taper && !bat_low && !s_q.lock[1];
    endsequence

    // neither a low battery nor lockout overrides the arc this cycle
    sequence seq_no_override;
        !bat_low && !s_q.lock[1];
    endsequence

    a_trickle_outputs: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_q.state == CHS_TRICKLE |-> !o_state_code_bit0 && !o_state_code_bit1 && !o_float_indicator)
        else $error("trickle outputs wrong");
    a_bulk_outputs: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_q.state == CHS_BULK |-> o_state_code_bit0 && !o_state_code_bit1 && !o_float_indicator)
        else $error("bulk outputs wrong");
    a_over_outputs: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_q.state == CHS_OVERCHARGE |-> !o_state_code_bit0 && o_state_code_bit1 && !o_float_indicator)
        else $error("overcharge outputs wrong");
    a_float_outputs: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_q.state == CHS_FLOAT |-> o_state_code_bit0 && o_state_code_bit1 && o_float_indicator)
        else $error("float outputs wrong");
    a_low_forces_trickle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_battery_low_sense [*3] |=> s_q.state == CHS_TRICKLE && !o_float_indicator)
        else $error("low battery did not force trickle");
    a_trickle_to_bulk: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (s_q.state == CHS_TRICKLE) ##0 seq_no_override |=> s_q.state == CHS_BULK)
        else $error("trickle to bulk missed");
    a_amp_steering: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_trickle_bias_en == !o_voltage_error_amp_en && (o_trickle_bias_en == (s_q.state == CHS_TRICKLE)))
        else $error("amplifier steering wrong");
    a_taper_to_float: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        seq_in_overcharge ##0 seq_taper_seen |=> s_q.state == CHS_FLOAT && o_float_indicator)
        else $error("taper did not reach float");
    a_legal_arcs: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $past(s_q.state) == CHS_TRICKLE && s_q.state != CHS_TRICKLE |-> s_q.state == CHS_BULK)
        else $error("illegal arc from trickle");
    a_bulk_amp_on: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_q.state == CHS_BULK |-> o_voltage_error_amp_en && !o_trickle_bias_en)
        else $error("bulk amplifier not enabled");
    a_low_clears_float: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        bat_low |=> !o_float_indicator)
        else $error("low battery left float indicator high");
    a_lockout_holds: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_q.lock[1] |=> s_q.state == CHS_TRICKLE)
        else $error("lockout did not hold trickle");

    // ****************************************
    // transition checks
    // ****************************************
    a_bulk_to_over: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (s_q.state == CHS_BULK && above_95) ##0 seq_no_override |=> s_q.state == CHS_OVERCHARGE)
        else $error("bulk to overcharge missed");
    a_float_to_bulk: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (s_q.state == CHS_FLOAT && below_90) ##0 seq_no_override |=> s_q.state == CHS_BULK)
        else $error("float to bulk missed");
    a_low_to_trickle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        bat_low |=> s_q.state == CHS_TRICKLE)
        else $error("synced low battery did not reach trickle");
    // a low battery may cut any state short, so trickle is a legal exit everywhere
    a_bulk_arcs: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $past(s_q.state) == CHS_BULK && s_q.state != CHS_BULK
        |-> s_q.state inside {CHS_OVERCHARGE, CHS_TRICKLE})
        else $error("illegal arc from bulk");
    a_over_arcs: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $past(s_q.state) == CHS_OVERCHARGE && s_q.state != CHS_OVERCHARGE
        |-> s_q.state inside {CHS_FLOAT, CHS_TRICKLE})
        else $error("illegal arc from overcharge");
    a_float_arcs: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $past(s_q.state) == CHS_FLOAT && s_q.state != CHS_FLOAT
        |-> s_q.state inside {CHS_BULK, CHS_TRICKLE})
        else $error("illegal arc from float");

endmodule

// ### verilog/chs_sync.sv
// two-flop level synchroniser, one per input bit
// assumes inputs are asynchronous comparator levels
`timescale 1ns/1ps
module chs_sync
    import chs_pkg::*;
#(
    parameter int WIDTH = 4
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } chs_sync_st_t;

    chs_sync_st_t s_q;
    chs_sync_st_t s_d;

    // first stage feeds only the second stage
    always_comb begin
        s_d = s_q;
        s_d.meta = i_async;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_sync = s_q.sync;

endmodule
